// File: fbsrp_top.sv
// Four-bit slice: register file ports, operand selection, ALU, pins
// Operation
// RULE1: Sixteen-by-four two-port RAM, latched outputs, four-bit paths.
// RULE2: RAM A output shows the word at the A address.
// RULE3: RAM B output shows the B-address word; writes go there.
// RULE4: Equal addresses give equal data on both ports.
// RULE5: Output latches pass when clock high, hold when low; the code opens them while ce_i is high instead.
// RULE6: Write strobe low writes result port data at B address.
// RULE7: R-source pick high selects external R, else RAM A.
// RULE8: B drive low drives RAM B out; high releases for S input.
// RULE9: Controller supplies a nine-bit microinstruction every cycle.
// RULE10: Instruction enable low lets Q and sign flop load; gates write.
// RULE11: Q and sign-compare flop change only on rising clock edge.
// RULE12: Carry in feeds ALU; carry out reported; both active high.
// RULE13: Generate at low/middle slices, sign at top slice.
// RULE14: Propagate at low/middle slices, overflow at top slice.
// RULE15: Open-collector zero pin high when outputs all low; special input.
// RULE16: Shift up: low pin in, high out; shift down reversed.
// RULE17: Tie low makes bottom slice, drives write indication on shared pin.
// RULE18: Bottom slice drives write indication low when instruction writes.
// RULE19: Tie high: shared pin input, high middle, low top; buffer off.
// RULE20: Result drive low drives shifter out; high releases result port.
// RULE21: Instruction bit zero high picks Q as S, else B source.
// RULE22: Five low instruction bits all low run special functions.
// RULE23: Controller keeps result drive high while driving the port.
`timescale 1ns/10ps
`default_nettype none
module fbsrp_top (
   input wire logic clk_i, // Slice clock, 125 MHz
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic ce_i, // Clock enable, freezes all state
   input wire logic [3:0] read_port_a_addr_i, // A address
   input wire logic [3:0] rw_port_b_addr_i, // B read and write address
   input wire logic ram_write_n_i, // RAM write strobe
   input wire logic [3:0] external_r_input_i, // External R data
   input wire logic r_source_pick_n_i, // High selects external R
   input wire logic [3:0] b_port_bus_i, // B port sensed level
   output logic [3:0] b_port_bus_o, // B port drive value
   output logic b_port_bus_oe_n_o, // B port enable, low drives
   input wire logic b_port_drive_n_i, // Low drives RAM B out
   input wire logic carry_input_i, // ALU carry in
   output logic carry_output_o, // ALU carry out
   input wire logic [8:0] microinstruction_bits_i, // Microinstruction
   input wire logic instr_enable_n_i, // Instruction enable
   output logic lookahead_or_sign_o, // Generate (low) or sign
   output logic propagate_or_overflow_pin_o, // Propagate (low) or overflow
   input wire logic zero_pin_i, // Zero pin sensed level
   output logic zero_pin_o, // Zero pin drive value, always low
   output logic zero_pin_oe_n_o, // Zero pin enable, low pulls down
   input wire logic alu_shift_low_pin_i, // Low shift pin level
   output logic alu_shift_low_pin_o, // Low shift pin drive value
   output logic alu_shift_low_pin_oe_n_o, // Low shift pin enable
   input wire logic alu_shift_high_pin_i, // High shift pin level
   output logic alu_shift_high_pin_o, // High shift pin drive value
   output logic alu_shift_high_pin_oe_n_o, // High shift pin enable
   input wire logic bottom_slice_tie_n_i, // Bottom slice strap
   input wire logic top_slice_select_n_i, // Shared pin sensed level
   output logic top_slice_select_n_o, // Shared pin write indication
   output logic top_slice_select_n_oe_n_o, // Shared pin enable
   input wire logic [3:0] result_data_port_i, // Result port sensed level
   output logic [3:0] result_data_port_o, // Result port drive value
   output logic result_data_port_oe_n_o, // Result port enable
   input wire logic result_drive_n_i, // Low drives shifter output
   output logic sign_compare_o // Sign-compare flip-flop
);
   typedef struct packed {
      logic [fbsrp_pkg::SYNC_W-1:0] sy1;
      logic [fbsrp_pkg::SYNC_W-1:0] sy2;
      logic [fbsrp_pkg::SYNC_W-1:0] sy3;
      logic [fbsrp_pkg::SYNC_W-1:0] strap;
      fbsrp_pkg::fbsrp_pos_e pos;
      logic [3:0] q;
      logic sgn;
      logic [3:0] y_o;
      logic y_oe_n;
      logic [3:0] b_o;
      logic b_oe_n;
      logic cout;
      logic gn;
      logic povr;
      logic z_o;
      logic z_oe_n;
      logic shl_o;
      logic shl_oe_n;
      logic shh_o;
      logic shh_oe_n;
      logic wr_o;
      logic wr_oe_n;
   } fbsrp_top_s;

   localparam fbsrp_top_s RESET_STATE = '{
      sy1: '1, sy2: '1, sy3: '1, strap: '1, pos: fbsrp_pkg::POS_IS,
      q: fbsrp_pkg::RESET_WORD, sgn: 1'b0, y_o: fbsrp_pkg::RESET_WORD, y_oe_n: 1'b1,
      b_o: fbsrp_pkg::RESET_WORD, b_oe_n: 1'b1, cout: 1'b0, gn: 1'b1, povr: 1'b1,
      z_o: 1'b0, z_oe_n: 1'b1, shl_o: 1'b0, shl_oe_n: 1'b1, shh_o: 1'b0,
      shh_oe_n: 1'b1, wr_o: 1'b1, wr_oe_n: 1'b1};

   fbsrp_top_s s_q;
   fbsrp_top_s s_d;
   fbsrp_rf_if rf ();

   logic [3:0] r_op;
   logic [3:0] s_op;
   logic [3:0] f_c;
   logic [3:0] y_c;
   logic [4:0] sum_c;
   logic [3:0] gen_c;
   logic [3:0] prop_c;
   logic g_all;
   logic p_all;
   logic ovr_c;
   logic arith_c;
   logic special_c;
   logic [1:0] shift_c;
   logic instr_wr_c;
   fbsrp_pkg::fbsrp_func_e func_c;

   // Register file hookup
   assign rf.addr_a = read_port_a_addr_i; // RULE2
   assign rf.addr_b = rw_port_b_addr_i; // RULE3
   assign rf.wr_en = ~ram_write_n_i & ce_i; // RULE6
   assign rf.wdata = result_drive_n_i ? result_data_port_i : y_c; // RULE20
   assign rf.latch_open = ce_i; // RULE5

   fbsrp_regfile u_regfile (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .rf(rf.mem)
   ); // RULE1

   // Instruction decode
   assign func_c = fbsrp_pkg::fbsrp_func_e'(microinstruction_bits_i[fbsrp_pkg::FUNC_MSB:fbsrp_pkg::FUNC_LSB]);
   assign special_c = microinstruction_bits_i[fbsrp_pkg::SPEC_MSB:0] == fbsrp_pkg::SPECIAL_CODE; // RULE22
   assign shift_c = microinstruction_bits_i[fbsrp_pkg::SHIFT_MSB:fbsrp_pkg::SHIFT_LSB];
   assign instr_wr_c = ~microinstruction_bits_i[fbsrp_pkg::QDEST_BIT];

   // Operand selection
   assign r_op = r_source_pick_n_i ? external_r_input_i : rf.dout_a; // RULE7
   always_comb begin
      if (microinstruction_bits_i[fbsrp_pkg::SRC_Q_BIT]) begin
         s_op = s_q.q; // RULE21
      end else if (b_port_drive_n_i) begin
         s_op = b_port_bus_i; // RULE8
      end else begin
         s_op = rf.dout_b; // RULE21
      end
   end

   // ALU function and carry chain
   always_comb begin
      logic [3:0] x;
      logic [3:0] z;
      x = r_op;
      z = s_op;
      arith_c = 1'b1;
      unique case (func_c)
         fbsrp_pkg::FN_SMR: begin x = ~r_op; z = s_op; end
         fbsrp_pkg::FN_RMS: begin x = r_op; z = ~s_op; end
         fbsrp_pkg::FN_ADD: begin x = r_op; z = s_op; end
         fbsrp_pkg::FN_S: begin x = 4'h0; z = s_op; end
         fbsrp_pkg::FN_NS: begin x = 4'h0; z = ~s_op; end
         fbsrp_pkg::FN_R: begin x = r_op; z = 4'h0; end
         fbsrp_pkg::FN_NR: begin x = ~r_op; z = 4'h0; end
         default: arith_c = 1'b0;
      endcase
      if (special_c) begin
         x = 4'h0;
         z = s_op;
         arith_c = 1'b1;
      end
      sum_c = {1'b0, x} + {1'b0, z} + {4'h0, carry_input_i}; // RULE12
      gen_c = x & z;
      prop_c = x | z;
      g_all = gen_c[3] | (prop_c[3] & gen_c[2]) | (&prop_c[3:2] & gen_c[1])
         | (&prop_c[3:1] & gen_c[0]);
      p_all = &prop_c;
      ovr_c = (x[3] & z[3] & ~sum_c[3]) | (~x[3] & ~z[3] & sum_c[3]);
      if (arith_c) begin
         f_c = sum_c[3:0];
      end else begin
         unique case (func_c)
            fbsrp_pkg::FN_HIGH: f_c = fbsrp_pkg::ALL_ONES;
            fbsrp_pkg::FN_LOW: f_c = 4'h0;
            fbsrp_pkg::FN_NRAS: f_c = ~r_op & s_op;
            fbsrp_pkg::FN_XNOR: f_c = ~(r_op ^ s_op);
            fbsrp_pkg::FN_XOR: f_c = r_op ^ s_op;
            fbsrp_pkg::FN_AND: f_c = r_op & s_op;
            fbsrp_pkg::FN_NOR: f_c = ~(r_op | s_op);
            fbsrp_pkg::FN_NAND: f_c = ~(r_op & s_op);
            default: f_c = r_op | s_op;
         endcase
      end
   end

   // Shifter with serial pins
   always_comb begin
      y_c = f_c;
      if (!special_c && shift_c == fbsrp_pkg::SHIFT_UP) begin
         y_c = {f_c[2:0], alu_shift_low_pin_i}; // RULE16
      end else if (!special_c && shift_c == fbsrp_pkg::SHIFT_DOWN) begin
         y_c = {alu_shift_high_pin_i, f_c[3:1]}; // RULE16
      end
   end

   // Next state of all slice registers
   always_comb begin
      s_d = s_q;
      // Strap synchroniser, change taken when stages two and three agree
      s_d.sy1 = {top_slice_select_n_i, bottom_slice_tie_n_i};
      s_d.sy2 = s_q.sy1;
      s_d.sy3 = s_q.sy2;
      if (s_q.sy2 == s_q.sy3) begin
         s_d.strap = s_q.sy3;
      end
      if (!s_q.strap[fbsrp_pkg::TIE_BIT]) begin
         s_d.pos = fbsrp_pkg::POS_LSS; // RULE17
      end else if (s_q.strap[fbsrp_pkg::TOP_BIT]) begin
         s_d.pos = fbsrp_pkg::POS_IS; // RULE19
      end else begin
         s_d.pos = fbsrp_pkg::POS_MSS; // RULE19
      end
      // Q and sign-compare load only when enabled
      if (!instr_enable_n_i) begin
         if (special_c) begin
            s_d.sgn = zero_pin_i; // RULE15
         end else begin
            s_d.sgn = f_c[3]; // RULE10
         end
         if (!instr_wr_c) begin
            s_d.q = f_c; // RULE11
         end
      end
      // Data pins
      s_d.y_o = y_c;
      s_d.y_oe_n = result_drive_n_i; // RULE20
      s_d.b_o = rf.dout_b;
      s_d.b_oe_n = b_port_drive_n_i; // RULE8
      s_d.cout = sum_c[4]; // RULE12
      // Status pins by slice position
      unique case (s_q.pos)
         fbsrp_pkg::POS_MSS: begin
            s_d.gn = f_c[3]; // RULE13
            s_d.povr = ovr_c; // RULE14
         end
         fbsrp_pkg::POS_LSS, fbsrp_pkg::POS_IS: begin
            s_d.gn = ~g_all; // RULE13
            s_d.povr = ~p_all; // RULE14
         end
      endcase
      // Zero pin released when all outputs low; input during specials
      s_d.z_o = 1'b0;
      s_d.z_oe_n = special_c | (y_c == 4'h0); // RULE15
      // Serial shift pins
      s_d.shl_o = 1'b0;
      s_d.shl_oe_n = 1'b1;
      s_d.shh_o = 1'b0;
      s_d.shh_oe_n = 1'b1;
      if (!special_c && shift_c == fbsrp_pkg::SHIFT_UP) begin
         s_d.shh_o = f_c[3]; // RULE16
         s_d.shh_oe_n = 1'b0;
      end else if (!special_c && shift_c == fbsrp_pkg::SHIFT_DOWN) begin
         s_d.shl_o = f_c[0]; // RULE16
         s_d.shl_oe_n = 1'b0;
      end
      // Write indication on shared pin, bottom slice only
      s_d.wr_o = ~(instr_wr_c & ~instr_enable_n_i); // RULE18
      s_d.wr_oe_n = s_q.pos != fbsrp_pkg::POS_LSS; // RULE17
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= RESET_STATE;
      end else if (ce_i) begin
         s_q <= s_d; // RULE11
      end
   end

   // Output pins straight from flops
   assign result_data_port_o = s_q.y_o;
   assign result_data_port_oe_n_o = s_q.y_oe_n;
   assign b_port_bus_o = s_q.b_o;
   assign b_port_bus_oe_n_o = s_q.b_oe_n;
   assign carry_output_o = s_q.cout;
   assign lookahead_or_sign_o = s_q.gn;
   assign propagate_or_overflow_pin_o = s_q.povr;
   assign zero_pin_o = s_q.z_o;
   assign zero_pin_oe_n_o = s_q.z_oe_n;
   assign alu_shift_low_pin_o = s_q.shl_o;
   assign alu_shift_low_pin_oe_n_o = s_q.shl_oe_n;
   assign alu_shift_high_pin_o = s_q.shh_o;
   assign alu_shift_high_pin_oe_n_o = s_q.shh_oe_n;
   assign top_slice_select_n_o = s_q.wr_o;
   assign top_slice_select_n_oe_n_o = s_q.wr_oe_n;
   assign sign_compare_o = s_q.sgn;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_q_hold_idle: assert property (ce_i && instr_enable_n_i |=> $stable(s_q.q) && $stable(s_q.sgn)) // RULE10
      else $error("Q or sign flop changed while disabled");
   a_q_load_f: assert property (ce_i && !instr_enable_n_i && !instr_wr_c |=> s_q.q == $past(f_c)) // RULE11
      else $error("Q did not load ALU result");
   a_r_ext_pass: assert property (ce_i && r_source_pick_n_i && func_c == fbsrp_pkg::FN_R
      && !special_c && !carry_input_i && shift_c == 2'h0 |=> s_q.y_o == $past(external_r_input_i)) // RULE7
      else $error("external R not used as operand");
   a_b_port_drive: assert property (ce_i |=> b_port_bus_oe_n_o == $past(b_port_drive_n_i)
      && b_port_bus_o == $past(rf.dout_b)) // RULE8
      else $error("B port drive wrong");
   a_y_port_drive: assert property (ce_i |=> result_data_port_oe_n_o == $past(result_drive_n_i)
      && result_data_port_o == $past(y_c)) // RULE20
      else $error("result port drive wrong");
   a_write_ind_lss: assert property (ce_i && s_q.pos == fbsrp_pkg::POS_LSS |=>
      !top_slice_select_n_oe_n_o && top_slice_select_n_o == $past(~(instr_wr_c & ~instr_enable_n_i))) // RULE18
      else $error("write indication wrong at bottom slice");
   a_shared_released: assert property (ce_i && s_q.pos != fbsrp_pkg::POS_LSS |=> top_slice_select_n_oe_n_o) // RULE19
      else $error("shared pin driven outside bottom slice");
   a_shift_up_pins: assert property (ce_i && !special_c && shift_c == fbsrp_pkg::SHIFT_UP |=>
      !alu_shift_high_pin_oe_n_o && alu_shift_low_pin_oe_n_o && alu_shift_high_pin_o == $past(f_c[3])) // RULE16
      else $error("shift-up pin roles wrong");
   a_msb_overflow: assert property (ce_i && s_q.pos == fbsrp_pkg::POS_MSS |=>
      propagate_or_overflow_pin_o == $past(ovr_c) && lookahead_or_sign_o == $past(f_c[3])) // RULE14
      else $error("top slice status wrong");
   a_carry_out: assert property (ce_i |=> carry_output_o == $past(sum_c[4])) // RULE12
      else $error("carry out wrong");
   a_zero_release: assert property (ce_i && !special_c && y_c == 4'h0 |=> zero_pin_oe_n_o) // RULE15
      else $error("zero pin pulled while result zero");

   c_lss_write: cover property (s_q.pos == fbsrp_pkg::POS_LSS && !top_slice_select_n_o);
   c_shift_down: cover property (!alu_shift_low_pin_oe_n_o);
   c_special: cover property (ce_i && special_c && !instr_enable_n_i);
endmodule // fbsrp_top
`default_nettype wire

// File: fbsrp_pkg.sv
// Constants, field positions and types shared by the four-bit slice files
package fbsrp_pkg;
   localparam int DATA_W = 4;
   localparam int ADDR_W = 4;
   localparam int WORDS = 16;
   localparam int INSTR_W = 9;
   localparam int SYNC_W = 2;
   localparam logic [3:0] RESET_WORD = 4'h0;
   localparam logic [3:0] ALL_ONES = 4'hF;
   // Instruction field positions
   localparam int SRC_Q_BIT = 0;
   localparam int FUNC_LSB = 1;
   localparam int FUNC_MSB = 4;
   localparam int SPEC_MSB = 4;
   localparam int SHIFT_LSB = 5;
   localparam int SHIFT_MSB = 6;
   localparam int QDEST_BIT = 8;
   localparam logic [4:0] SPECIAL_CODE = 5'h00;
   // Shifter codes in the shift field
   localparam logic [1:0] SHIFT_DOWN = 2'h1;
   localparam logic [1:0] SHIFT_UP = 2'h2;
   // Strap bit positions inside the synchroniser
   localparam int TIE_BIT = 0;
   localparam int TOP_BIT = 1;
   // ALU function codes
   typedef enum logic [3:0] {
      FN_HIGH = 4'h0, FN_SMR = 4'h1, FN_RMS = 4'h2, FN_ADD = 4'h3,
      FN_S = 4'h4, FN_NS = 4'h5, FN_R = 4'h6, FN_NR = 4'h7,
      FN_LOW = 4'h8, FN_NRAS = 4'h9, FN_XNOR = 4'hA, FN_XOR = 4'hB,
      FN_AND = 4'hC, FN_NOR = 4'hD, FN_NAND = 4'hE, FN_OR = 4'hF
   } fbsrp_func_e;
   // Slice position, one-hot
   typedef enum logic [2:0] {
      POS_LSS = 3'b001,
      POS_IS = 3'b010,
      POS_MSS = 3'b100
   } fbsrp_pos_e;
endpackage

// File: fbsrp_rf_if.sv
// Signals between the slice datapath and its two-port register file
`timescale 1ns/10ps
`default_nettype none
interface fbsrp_rf_if;
   logic [fbsrp_pkg::ADDR_W-1:0] addr_a;
   logic [fbsrp_pkg::ADDR_W-1:0] addr_b;
   logic [fbsrp_pkg::DATA_W-1:0] wdata;
   logic wr_en;
   logic latch_open;
   logic [fbsrp_pkg::DATA_W-1:0] dout_a;
   logic [fbsrp_pkg::DATA_W-1:0] dout_b;
   modport ctl (output addr_a, addr_b, wdata, wr_en, latch_open, input dout_a, dout_b);
   modport mem (input addr_a, addr_b, wdata, wr_en, latch_open, output dout_a, dout_b);
endinterface
`default_nettype wire

// File: fbsrp_regfile.sv
// Sixteen-word two-port register file with latched A and B outputs
`timescale 1ns/10ps
`default_nettype none
module fbsrp_regfile (
   input wire logic clk_i, // Slice clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic ce_i, // Clock enable
   fbsrp_rf_if.mem rf // Register file port
);
   typedef struct packed {
      logic [fbsrp_pkg::WORDS-1:0][fbsrp_pkg::DATA_W-1:0] mem;
      logic [fbsrp_pkg::DATA_W-1:0] held_a;
      logic [fbsrp_pkg::DATA_W-1:0] held_b;
   } fbsrp_rf_s;

   fbsrp_rf_s s_q;
   fbsrp_rf_s s_d;
   logic [fbsrp_pkg::DATA_W-1:0] rd_a;
   logic [fbsrp_pkg::DATA_W-1:0] rd_b;

   // Both ports read the array independently
   assign rd_a = s_q.mem[rf.addr_a]; // RULE2
   assign rd_b = s_q.mem[rf.addr_b]; // RULE3
   // Output latches: pass while open, hold otherwise
   assign rf.dout_a = rf.latch_open ? rd_a : s_q.held_a; // RULE5
   assign rf.dout_b = rf.latch_open ? rd_b : s_q.held_b; // RULE5

   // Next state: latch capture and write at port-B address
   always_comb begin
      s_d = s_q;
      if (rf.latch_open) begin
         s_d.held_a = rd_a;
         s_d.held_b = rd_b;
      end
      if (rf.wr_en) begin
         s_d.mem[rf.addr_b] = rf.wdata; // RULE6
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_same_addr_equal: assert property (rf.latch_open && rf.addr_a == rf.addr_b |-> rf.dout_a == rf.dout_b) // RULE4
      else $error("same address gives different port data");
   a_write_stores: assert property (ce_i && rf.wr_en |=> s_q.mem[$past(rf.addr_b)] == $past(rf.wdata)) // RULE6
      else $error("ram write did not store data");
   a_latch_holds: assert property (!rf.latch_open ##1 !rf.latch_open |-> $stable(rf.dout_a) && $stable(rf.dout_b)) // RULE5
      else $error("closed latch changed");
   c_write: cover property (ce_i && rf.wr_en);
endmodule // fbsrp_regfile
`default_nettype wire

// File: fbsrp_partner.sv
// Controller and neighbour slices: resolve the shared pins of one slice
`timescale 1ns/10ps
`default_nettype none
module fbsrp_partner (
   input wire logic result_drive_n_i, // Controller result drive control
   input wire logic [3:0] y_ext_i, // Data offered onto result port
   input wire logic [3:0] y_dut_i, // Slice result drive value
   input wire logic y_oe_n_i, // Slice result enable
   output logic [3:0] y_o, // Result port level
   input wire logic [3:0] b_ext_i, // Data offered onto B port
   input wire logic [3:0] b_dut_i, // Slice B drive value
   input wire logic b_oe_n_i, // Slice B enable
   output logic [3:0] b_o, // B port level
   input wire logic z_oe_n_i, // Zero pin pull-down enable
   output logic z_o, // Zero pin level
   input wire logic [1:0] sh_dut_i, // Shift pin values, low then high
   input wire logic [1:0] sh_oe_n_i, // Shift pin enables
   input wire logic [1:0] sh_nb_i, // Neighbour shift data
   output logic [1:0] sh_o, // Shift pin levels
   input wire logic w_dut_i, // Write indication value
   input wire logic w_oe_n_i, // Write indication enable
   input wire logic strap_i, // Level tied on shared pin
   output logic w_o // Shared pin level
);
   // Controller drives the result port only while the slice lets go
   assign y_o = !y_oe_n_i ? y_dut_i : (result_drive_n_i ? y_ext_i : ~y_dut_i);
   // Released B port carries controller data
   assign b_o = !b_oe_n_i ? b_dut_i : b_ext_i;
   // Open collector with pull-up
   assign z_o = !z_oe_n_i ? 1'b0 : 1'b1;
   // Neighbour drives whichever shift pin the slice leaves free
   assign sh_o[0] = !sh_oe_n_i[0] ? sh_dut_i[0] : sh_nb_i[0];
   assign sh_o[1] = !sh_oe_n_i[1] ? sh_dut_i[1] : sh_nb_i[1];
   assign w_o = !w_oe_n_i ? w_dut_i : strap_i;
endmodule // fbsrp_partner
`default_nettype wire

// File: fbsrp_top_test.sv
// Self-checking bench for the four-bit slice
`timescale 1ns/10ps
`default_nettype none
module fbsrp_top_test;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic [3:0] aa = 4'h0, ba = 4'h0, er = 4'h0, yx = 4'h0, bx = 4'h0;
   logic wr_n = 1'b1, pick_n = 1'b0, bdrv_n = 1'b0, cin = 1'b0, en_n = 1'b1;
   logic tie_n = 1'b0, strap = 1'b1, ydrv_n = 1'b0;
   logic [8:0] mi = 9'h000;
   logic [1:0] nb = 2'h3;
   logic [3:0] mem [16];
   int bad_count = 0;
   int checks = 0;
   logic [3:0] b_o, y_o, y_l, b_l, v;
   logic b_oe, co, gs, po, z_o, z_oe, w_o, w_oe, w_l, sc, z_l;
   logic [1:0] sh_o, sh_oe, sh_l;
   logic y_oe;
   fbsrp_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .read_port_a_addr_i(aa),
      .rw_port_b_addr_i(ba), .ram_write_n_i(wr_n), .external_r_input_i(er),
      .r_source_pick_n_i(pick_n), .b_port_bus_i(b_l), .b_port_bus_o(b_o),
      .b_port_bus_oe_n_o(b_oe), .b_port_drive_n_i(bdrv_n), .carry_input_i(cin),
      .carry_output_o(co), .microinstruction_bits_i(mi), .instr_enable_n_i(en_n),
      .lookahead_or_sign_o(gs), .propagate_or_overflow_pin_o(po), .zero_pin_i(z_l),
      .zero_pin_o(z_o), .zero_pin_oe_n_o(z_oe), .alu_shift_low_pin_i(sh_l[0]),
      .alu_shift_low_pin_o(sh_o[0]), .alu_shift_low_pin_oe_n_o(sh_oe[0]),
      .alu_shift_high_pin_i(sh_l[1]), .alu_shift_high_pin_o(sh_o[1]),
      .alu_shift_high_pin_oe_n_o(sh_oe[1]), .bottom_slice_tie_n_i(tie_n),
      .top_slice_select_n_i(w_l), .top_slice_select_n_o(w_o),
      .top_slice_select_n_oe_n_o(w_oe), .result_data_port_i(y_l),
      .result_data_port_o(y_o), .result_data_port_oe_n_o(y_oe), .result_drive_n_i(ydrv_n),
      .sign_compare_o(sc));
   fbsrp_partner nbr (.result_drive_n_i(ydrv_n), .y_ext_i(yx), .y_dut_i(y_o), .y_oe_n_i(y_oe),
      .y_o(y_l), .b_ext_i(bx), .b_dut_i(b_o), .b_oe_n_i(b_oe), .b_o(b_l), .z_oe_n_i(z_oe),
      .z_o(z_l), .sh_dut_i(sh_o), .sh_oe_n_i(sh_oe), .sh_nb_i(nb), .sh_o(sh_l),
      .w_dut_i(w_o), .w_oe_n_i(w_oe), .strap_i(strap), .w_o(w_l));
   // Clock, 8 ns period
   always #4 clk_i = ~clk_i;
   // Instruction word from its fields
   function automatic logic [8:0] ins(input logic qd, input logic [1:0] sh,
      input logic [3:0] fn, input logic sq);
      return {qd, 1'b0, sh, fn, sq};
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One microcycle: present the instruction, let the edge land
   task automatic step(input logic [8:0] i);
      mi = i;
      @(posedge clk_i);
      #2;
   endtask
   // Write external data through the released result port
   task automatic wr(input logic [3:0] a, input logic [3:0] d, input logic wn);
      ba = a;
      yx = d;
      ydrv_n = 1'b1;
      // Slice lets go of the result port one edge after the release request
      step(ins(1'b1, 2'h0, fbsrp_pkg::FN_R, 1'b0));
      wr_n = wn;
      step(ins(1'b1, 2'h0, fbsrp_pkg::FN_R, 1'b0));
      if (!wn) mem[a] = d;
      cmp("result oe", 4'h1, {3'h0, y_oe});
      wr_n = 1'b1;
      ydrv_n = 1'b0;
   endtask
   // Read A through the ALU and B through the B port
   task automatic rd(input logic [3:0] a, input logic [3:0] b);
      aa = a;
      ba = b;
      pick_n = 1'b0;
      bdrv_n = 1'b0;
      cin = 1'b0;
      step(ins(1'b1, 2'h0, fbsrp_pkg::FN_R, 1'b0));
      cmp("b port", mem[b], b_o);
      cmp("b oe", 4'h0, {3'h0, b_oe});
      cmp("a via alu", mem[a], y_o);
      cmp("result oe", 4'h0, {3'h0, y_oe});
   endtask
   // Watchdog
   initial begin
      #40000;
      bad_count++;
      conclude();
   end
   // Main sequence
   initial begin
      v = 4'($urandom(34));
      foreach (mem[k]) mem[k] = 4'h0;
      repeat (20) @(posedge clk_i);
      #2;
      rst_n_i = 1'b1;
      repeat (8) step(9'h100);
      for (int k = 0; k < 16; k++) wr(4'(k), 4'($urandom), 1'b0);
      for (int k = 0; k < 16; k++) rd(4'(k), 4'(15 - k));
      for (int k = 0; k < 60; k++) begin
         wr(4'($urandom), 4'($urandom), 1'($urandom % 3 == 0));
         v = 4'($urandom);
         rd(v, v);
         rd(4'($urandom), 4'($urandom));
      end
      // External R, external S, carry and status at the bottom slice
      pick_n = 1'b1;
      bdrv_n = 1'b1;
      er = 4'hF;
      bx = 4'h0;
      cin = 1'b1;
      // First edge releases the B port, second uses the external S
      repeat (2) step(ins(1'b1, 2'h0, fbsrp_pkg::FN_ADD, 1'b0));
      cmp("sum", 4'h0, y_o);
      cmp("carry", 4'h1, {3'h0, co});
      cmp("b oe", 4'h1, {3'h0, b_oe});
      cmp("zero level", 4'h1, {3'h0, z_l});
      cmp("generate", 4'h1, {3'h0, gs});
      cmp("propagate", 4'h0, {3'h0, po});
      er = 4'h1;
      bx = 4'h2;
      step(ins(1'b1, 2'h0, fbsrp_pkg::FN_ADD, 1'b0));
      cmp("sum", 4'h4, y_o);
      cmp("carry", 4'h0, {3'h0, co});
      cmp("zero level", 4'h0, {3'h0, z_l});
      // Special function passes S plus carry
      bx = 4'h5;
      step(ins(1'b1, 2'h0, 4'h0, 1'b0));
      cmp("special", 4'h6, y_o);
      // Q loads only when enabled, then serves as S
      cin = 1'b0;
      en_n = 1'b0;
      er = 4'hA;
      step(ins(1'b1, 2'h0, fbsrp_pkg::FN_R, 1'b0));
      en_n = 1'b1;
      er = 4'h5;
      step(ins(1'b1, 2'h0, fbsrp_pkg::FN_R, 1'b0));
      cmp("write ind held", 4'h1, {3'h0, w_o});
      step(ins(1'b1, 2'h0, fbsrp_pkg::FN_S, 1'b1));
      cmp("q as s", 4'hA, y_o);
      // Write indication at the bottom slice
      en_n = 1'b0;
      step(ins(1'b0, 2'h0, fbsrp_pkg::FN_R, 1'b0));
      cmp("write ind", 4'h0, {3'h0, w_o});
      cmp("write ind oe", 4'h0, {3'h0, w_oe});
      // Shift up and down through the neighbour pins
      er = 4'h9;
      step(ins(1'b1, fbsrp_pkg::SHIFT_UP, fbsrp_pkg::FN_R, 1'b0));
      cmp("shift up", 4'h3, y_o);
      cmp("shift pins oe", 4'h1, {2'h0, sh_oe});
      cmp("shift out", 4'h1, {3'h0, sh_l[1]});
      er = 4'h6;
      step(ins(1'b1, fbsrp_pkg::SHIFT_DOWN, fbsrp_pkg::FN_R, 1'b0));
      cmp("shift down", 4'hB, y_o);
      cmp("shift pins oe", 4'h2, {2'h0, sh_oe});
      cmp("shift out", 4'h0, {3'h0, sh_l[0]});
      // Frozen clock enable holds the result port output
      ce_i = 1'b0;
      er = 4'h1;
      repeat (3) step(ins(1'b1, 2'h0, fbsrp_pkg::FN_R, 1'b0));
      cmp("held", 4'hB, y_o);
      ce_i = 1'b1;
      // Top slice: sign and overflow
      tie_n = 1'b1;
      strap = 1'b0;
      er = 4'h7;
      bx = 4'h1;
      repeat (14) step(ins(1'b1, 2'h0, fbsrp_pkg::FN_ADD, 1'b0));
      cmp("write ind oe", 4'h1, {3'h0, w_oe});
      cmp("sign", 4'h1, {3'h0, gs});
      cmp("overflow", 4'h1, {3'h0, po});
      conclude();
   end
endmodule // fbsrp_top_test
`default_nettype wire
